/* File: rtl/rmtl_capture.sv */
// Captures the frequency correction once per reception.
// Assumes sync_found is a one-cycle pulse in the clock domain.
`timescale 1ns/1ps

module rmtl_capture #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    // Capture
    input  wire logic             sync_in,
    input  wire logic [WIDTH-1:0] value_in,
    output logic      [WIDTH-1:0] held_out,
    output logic                  event_out
);
    if (WIDTH < 1) begin : g_width_check
        $error("WIDTH must be positive.");
    end

    // Load only on the sync pulse, hold otherwise.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            held_out <= '0;
        end else if (sync_in) begin
            held_out <= value_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            event_out <= 1'b0;
        end else begin
            event_out <= sync_in;
        end
    end
endmodule // rmtl_capture

/* File: rtl/rmtl_defs.svh */
// Constants for the receiver modem timing and level register bank.
// Assumes inclusion by bare name from the package and the modules.
`ifndef RMTL_DEFS_SVH
`define RMTL_DEFS_SVH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define RMTL_IDX_NCO_MID      8'h22
`define RMTL_IDX_NCO_LOW      8'h23
`define RMTL_IDX_GAIN_HIGH    8'h24
`define RMTL_IDX_GAIN_LOW     8'h25
`define RMTL_IDX_LEVEL        8'h26
`define RMTL_IDX_THRESH       8'h27
`define RMTL_IDX_ANT1         8'h28
`define RMTL_IDX_ANT2         8'h29
`define RMTL_IDX_FC_LIMIT     8'h2a
`define RMTL_IDX_FC_HIGH      8'h2b
`define RMTL_IDX_OOK_CTL      8'h2c
`define RMTL_IDX_OOK_LOW      8'h2d
`define RMTL_IDX_IRQ_STATUS   8'h40
`define RMTL_IDX_IRQ_MASK     8'h41
`define RMTL_IDX_MANCH        8'h42

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RMTL_RST_NCO_MID      8'h00
`define RMTL_RST_NCO_LOW      8'hae
`define RMTL_RST_GAIN_HIGH    8'h02
`define RMTL_RST_GAIN_LOW     8'h00
`define RMTL_RST_LEVEL        8'h00
`define RMTL_RST_THRESH       8'h1e
`define RMTL_RST_ANT          8'h00
`define RMTL_RST_FC_LIMIT     8'h2a
`define RMTL_RST_OOK_CTL      8'h2c
`define RMTL_RST_OOK_LOW      8'h00
`define RMTL_RST_IRQ_MASK     8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RMTL_OOK_FRZ_BIT      5
`define RMTL_OOK_PEAK_BIT     4
`define RMTL_OOK_MA_BIT       3
`define RMTL_HI3_MASK         8'h07
`define RMTL_OOK_RW_MASK      8'h3f
`define RMTL_IRQ_CCA_BIT      0
`define RMTL_IRQ_SYNC_BIT     1
`define RMTL_IRQ_MASK_BITS    8'h03
`define RMTL_NCO_WIDTH        20

`endif

/* File: rtl/rmtl_level.sv */
// Holds the measured signal levels and flags each new level above the threshold.
// Assumes meas_valid marks a new set of measurements.
`timescale 1ns/1ps
`include "rmtl_defs.svh"

module rmtl_level (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // Measurements
    input  wire logic       valid_in,
    input  wire logic [7:0] level_in,
    input  wire logic [7:0] ant1_in,
    input  wire logic [7:0] ant2_in,
    input  wire logic [7:0] thresh_in,
    // Held values and threshold event
    output logic      [7:0] level_out,
    output logic      [7:0] ant1_out,
    output logic      [7:0] ant2_out,
    output logic            above_out
);
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_out <= `RMTL_RST_LEVEL;
            ant1_out  <= `RMTL_RST_ANT;
            ant2_out  <= `RMTL_RST_ANT;
        end else if (valid_in) begin
            level_out <= level_in;
            ant1_out  <= ant1_in;
            ant2_out  <= ant2_in;
        end
    end

    // One-cycle event when a new level is above the threshold.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            above_out <= 1'b0;
        end else begin
            above_out <= valid_in && (level_in > thresh_in);
        end
    end
endmodule // rmtl_level

/* File: rtl/rmtl_pkg.sv */
// Types shared by the receiver modem timing and level register bank.
// Assumes the constants header is on the include path.
`include "rmtl_defs.svh"

package rmtl_pkg;

    // ------------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } rmtl_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rmtl_axi_rsp_t;

    // ------------------------------------------------------------------
    // Modem side carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] ant1;
        logic [7:0] ant2;
        logic       meas_valid;
        logic [9:0] fc_value;
        logic       sync_found;
    } rmtl_modem_in_t;

    typedef struct packed {
        logic [19:0] nco_offset;
        logic [10:0] timing_gain;
        logic [7:0]  fc_limit;
        logic        ook_freeze;
        logic        peak_det_en;
        logic        ma_en;
        logic [10:0] ook_count;
        logic        manch_flag;
    } rmtl_modem_ctl_t;

    typedef struct packed {
        logic [7:0] index;
        logic       hit;
    } rmtl_decode_t;

    typedef enum logic [2:0] {
        RMTL_R_IDLE = 3'b001,
        RMTL_R_DATA = 3'b010,
        RMTL_R_WAIT = 3'b100
    } rmtl_rd_state_t;

endpackage

/* File: rtl/rmtl_top.sv */
// Register bank for modem timing, signal levels and on-off keying.
// Assumes an AXI4-Lite master and a modem core in the same clock domain.
// Operation
// - NCO offset middle and low bytes, read/write
// - NCO offset is twenty bits overall
// - Eleven-bit timing loop gain across two registers
// - Manchester flag is one when enabled
// - Signal level read-only, zero after reset
// - Level above threshold raises clear-channel interrupt
// - Two read-only antenna level registers
// - Frequency correction limiter, read/write, resets 0x2a
// - Ten-bit correction split across two registers
// - Correction captured once at sync word
// - Freeze bit holds on-off gain control
// - Peak detector enabled by bit four
// - Moving average enabled by bit three
// - Eleven-bit on-off counter, read/write
`timescale 1ns/1ps
`include "rmtl_defs.svh"

module rmtl_top
    import rmtl_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      rstn_in,
    // AXI4-Lite slave
    input  wire rmtl_pkg::rmtl_axi_req_t   axi_req_in,
    output rmtl_pkg::rmtl_axi_rsp_t        axi_rsp_out,
    // Modem core
    input  wire rmtl_pkg::rmtl_modem_in_t  modem_in,
    output rmtl_pkg::rmtl_modem_ctl_t      modem_ctl_out,
    // Interrupt
    output logic                           irq_out
);
    import rmtl_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rstn_r;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_r <= 1'b0;
            rstn_r     <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rstn_r     <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic rmtl_decode_t decode(input logic [31:0] addr);
        rmtl_decode_t d;
        d.index = addr[9:2];
        d.hit   = (addr[31:10] == 22'h00_0000) && (addr[1:0] == 2'b00);
        return d;
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] nco_mid_r;
    logic [7:0] nco_low_r;
    logic [3:0] nco_top_r;
    logic [2:0] gain_high_r;
    logic [7:0] gain_low_r;
    logic [7:0] thresh_r;
    logic [7:0] fc_limit_r;
    logic [5:0] ook_ctl_r;
    logic [7:0] ook_low_r;
    logic [7:0] irq_mask_r;
    logic [7:0] irq_stat_r;
    logic       manch_r;

    logic [7:0] level_w;
    logic [7:0] ant1_w;
    logic [7:0] ant2_w;
    logic       above_w;
    logic [9:0] fc_w;
    logic       sync_ev_w;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic        aw_held_r;
    logic [31:0] aw_addr_r;
    logic        w_held_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        awready_r;
    logic        wready_r;
    logic        wr_go;
    logic        wr_en;
    rmtl_decode_t wr_dec;
    logic [7:0]  wr_byte;

    assign wr_go   = aw_held_r && w_held_r && !bvalid_r;
    assign wr_dec  = decode(aw_addr_r);
    assign wr_en   = wr_go && wr_dec.hit && w_strb_r[0];
    assign wr_byte = w_data_r[7:0];

    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
            awready_r <= 1'b0;
        end else begin
            awready_r <= !aw_held_r && !axi_req_in.awvalid;
            if (axi_req_in.awvalid && awready_r) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= axi_req_in.awaddr;
                awready_r <= 1'b0;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (!aw_held_r && !(axi_req_in.awvalid && awready_r)) begin
                awready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            wready_r <= 1'b0;
        end else begin
            if (axi_req_in.wvalid && wready_r) begin
                w_held_r <= 1'b1;
                w_data_r <= axi_req_in.wdata;
                w_strb_r <= axi_req_in.wstrb;
                wready_r <= 1'b0;
            end else begin
                if (wr_go) begin
                    w_held_r <= 1'b0;
                end
                wready_r <= !w_held_r;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            bvalid_r <= 1'b0;
            bresp_r  <= 2'b00;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_dec.hit ? 2'b00 : 2'b10;
        end else if (bvalid_r && axi_req_in.bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            nco_mid_r   <= `RMTL_RST_NCO_MID;
            nco_low_r   <= `RMTL_RST_NCO_LOW;
            nco_top_r   <= 4'h0;
            gain_high_r <= 3'(`RMTL_RST_GAIN_HIGH & `RMTL_HI3_MASK);
            gain_low_r  <= `RMTL_RST_GAIN_LOW;
            thresh_r    <= `RMTL_RST_THRESH;
            fc_limit_r  <= `RMTL_RST_FC_LIMIT;
            ook_ctl_r   <= 6'(`RMTL_RST_OOK_CTL & `RMTL_OOK_RW_MASK);
            ook_low_r   <= `RMTL_RST_OOK_LOW;
            irq_mask_r  <= `RMTL_RST_IRQ_MASK;
            manch_r     <= 1'b0;
        end else if (wr_en) begin
            unique case (wr_dec.index)
                `RMTL_IDX_NCO_MID:   nco_mid_r  <= wr_byte;
                `RMTL_IDX_NCO_LOW:   nco_low_r  <= wr_byte;
                `RMTL_IDX_GAIN_HIGH: begin
                    gain_high_r <= wr_byte[2:0];
                end
                `RMTL_IDX_GAIN_LOW:  gain_low_r <= wr_byte;
                `RMTL_IDX_THRESH:    thresh_r   <= wr_byte;
                `RMTL_IDX_FC_LIMIT:  fc_limit_r <= wr_byte;
                `RMTL_IDX_OOK_CTL: begin
                    ook_ctl_r <= wr_byte[5:0];
                end
                `RMTL_IDX_OOK_LOW:   ook_low_r  <= wr_byte;
                `RMTL_IDX_IRQ_MASK: begin
                    irq_mask_r <= wr_byte & `RMTL_IRQ_MASK_BITS;
                end
                `RMTL_IDX_MANCH: begin
                    manch_r   <= wr_byte[0];
                    nco_top_r <= wr_byte[7:4];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    rmtl_rd_state_t rd_state_r;
    logic [31:0]    rdata_r;
    logic [1:0]     rresp_r;
    logic           arready_r;
    rmtl_decode_t   rd_dec;
    logic           rd_take;
    logic           stat_clr;
    logic [7:0]     rd_byte;

    assign rd_dec   = decode(axi_req_in.araddr);
    assign rd_take  = axi_req_in.arvalid && arready_r;
    assign stat_clr = rd_take && rd_dec.hit &&
                      (rd_dec.index == `RMTL_IDX_IRQ_STATUS);

    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_dec.index)
            `RMTL_IDX_NCO_MID:    rd_byte = nco_mid_r;
            `RMTL_IDX_NCO_LOW:    rd_byte = nco_low_r;
            `RMTL_IDX_GAIN_HIGH:  rd_byte = {5'b0_0000, gain_high_r};
            `RMTL_IDX_GAIN_LOW:   rd_byte = gain_low_r;
            `RMTL_IDX_LEVEL:      rd_byte = level_w;
            `RMTL_IDX_THRESH:     rd_byte = thresh_r;
            `RMTL_IDX_ANT1:       rd_byte = ant1_w;
            `RMTL_IDX_ANT2:       rd_byte = ant2_w;
            `RMTL_IDX_FC_LIMIT:   rd_byte = fc_limit_r;
            `RMTL_IDX_FC_HIGH:    rd_byte = fc_w[9:2];
            `RMTL_IDX_OOK_CTL:    rd_byte = {fc_w[1:0], ook_ctl_r};
            `RMTL_IDX_OOK_LOW:    rd_byte = ook_low_r;
            `RMTL_IDX_IRQ_STATUS: rd_byte = irq_stat_r;
            `RMTL_IDX_IRQ_MASK:   rd_byte = irq_mask_r;
            `RMTL_IDX_MANCH:      rd_byte = {nco_top_r, 3'b000, manch_r};
            default:              rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            rd_state_r <= RMTL_R_WAIT;
            arready_r  <= 1'b0;
            rdata_r    <= 32'h0000_0000;
            rresp_r    <= 2'b00;
        end else begin
            unique case (rd_state_r)
                RMTL_R_WAIT: begin
                    arready_r  <= 1'b1;
                    rd_state_r <= RMTL_R_IDLE;
                end
                RMTL_R_IDLE: begin
                    if (rd_take) begin
                        arready_r  <= 1'b0;
                        rdata_r    <= rd_dec.hit ? {24'h00_0000, rd_byte}
                                                 : 32'h0000_0000;
                        rresp_r    <= rd_dec.hit ? 2'b00 : 2'b10;
                        rd_state_r <= RMTL_R_DATA;
                    end
                end
                RMTL_R_DATA: begin
                    if (axi_req_in.rready) begin
                        arready_r  <= 1'b1;
                        rd_state_r <= RMTL_R_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [7:0] irq_set;

    always_comb begin
        irq_set = 8'h00;
        irq_set[`RMTL_IRQ_CCA_BIT]  = above_w;
        irq_set[`RMTL_IRQ_SYNC_BIT] = sync_ev_w;
    end

    // A new event wins over the clear caused by a status read.
    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            irq_stat_r <= 8'h00;
        end else begin
            irq_stat_r <= (stat_clr ? 8'h00 : irq_stat_r) | irq_set;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(((stat_clr ? 8'h00 : irq_stat_r) | irq_set)
                         & irq_mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Modem control outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_r) begin
        if (!rstn_r) begin
            modem_ctl_out <= '0;
        end else begin
            modem_ctl_out.nco_offset  <= {nco_top_r, nco_mid_r,
                                          nco_low_r};
            modem_ctl_out.timing_gain <= {gain_high_r, gain_low_r};
            modem_ctl_out.fc_limit    <= fc_limit_r;
            modem_ctl_out.ook_freeze  <=
                ook_ctl_r[`RMTL_OOK_FRZ_BIT];
            modem_ctl_out.peak_det_en <=
                ook_ctl_r[`RMTL_OOK_PEAK_BIT];
            modem_ctl_out.ma_en       <=
                ook_ctl_r[`RMTL_OOK_MA_BIT];
            modem_ctl_out.ook_count   <= {ook_ctl_r[2:0], ook_low_r};
            modem_ctl_out.manch_flag  <= manch_r;
        end
    end

    always_comb begin
        axi_rsp_out         = '0;
        axi_rsp_out.awready = awready_r;
        axi_rsp_out.wready  = wready_r;
        axi_rsp_out.bvalid  = bvalid_r;
        axi_rsp_out.bresp   = bresp_r;
        axi_rsp_out.arready = arready_r;
        axi_rsp_out.rvalid  = (rd_state_r == RMTL_R_DATA);
        axi_rsp_out.rdata   = rdata_r;
        axi_rsp_out.rresp   = rresp_r;
    end

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    rmtl_level u_level (
        .clk_in    (clk_in),
        .rstn_in   (rstn_r),
        .valid_in  (modem_in.meas_valid),
        .level_in  (modem_in.level),
        .ant1_in   (modem_in.ant1),
        .ant2_in   (modem_in.ant2),
        .thresh_in (thresh_r),
        .level_out (level_w),
        .ant1_out  (ant1_w),
        .ant2_out  (ant2_w),
        .above_out (above_w)
    );

    rmtl_capture #(
        .WIDTH (10)
    ) u_capture (
        .clk_in    (clk_in),
        .rstn_in   (rstn_r),
        .sync_in   (modem_in.sync_found),
        .value_in  (modem_in.fc_value),
        .held_out  (fc_w),
        .event_out (sync_ev_w)
    );
endmodule // rmtl_top

/* File: sim/rmtl_asserts.sv */
// Port checker for the modem timing and level register bank.
// Assumes binding to rmtl_top after the package is compiled.
`timescale 1ns/1ps

module rmtl_asserts (
    // Watched ports
    input wire logic                      clk_in,
    input wire logic                      rstn_in,
    input wire rmtl_pkg::rmtl_axi_req_t   axi_req_in,
    input wire rmtl_pkg::rmtl_axi_rsp_t   axi_rsp_out,
    input wire rmtl_pkg::rmtl_modem_in_t  modem_in,
    input wire rmtl_pkg::rmtl_modem_ctl_t modem_ctl_out,
    input wire logic                      irq_out
);
    import rmtl_pkg::*;
    logic [3:0] up_r;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) up_r <= 4'h0;
        else if (up_r != 4'hf) up_r <= up_r + 4'h1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    AST_NCO_RST: assert property (
        up_r == 4'h5 |-> modem_ctl_out.nco_offset == 20'h0_00ae)
        else $error("nco offset reset wrong");
    AST_GAIN_RST: assert property (
        up_r == 4'h5 |-> modem_ctl_out.timing_gain == 11'h200)
        else $error("timing gain reset wrong");
    AST_LIMIT_RST: assert property (
        up_r == 4'h5 |-> modem_ctl_out.fc_limit == 8'h2a)
        else $error("limiter reset wrong");
    AST_OOK_RST: assert property (
        up_r == 4'h5 |-> {modem_ctl_out.ook_freeze, modem_ctl_out.peak_det_en,
        modem_ctl_out.ma_en, modem_ctl_out.ook_count} == 14'h2c00)
        else $error("on-off control reset wrong");
    AST_RD_ANSWER: assert property (
        axi_req_in.arvalid && axi_rsp_out.arready |=> axi_rsp_out.rvalid)
        else $error("read answer late");
    AST_RD_HOLD: assert property (
        axi_rsp_out.rvalid && !axi_req_in.rready |=>
        axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
        else $error("read data dropped");
    AST_RD_UPPER: assert property (
        axi_rsp_out.rvalid |-> axi_rsp_out.rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    AST_WR_HOLD: assert property (
        axi_rsp_out.bvalid && !axi_req_in.bready |=> axi_rsp_out.bvalid)
        else $error("write response dropped");
    AST_CTL_CAUSE: assert property (
        up_r == 4'hf && $changed(modem_ctl_out) |->
        $past(axi_req_in.wvalid) || $past(axi_req_in.wvalid, 2) ||
        $past(axi_req_in.wvalid, 3))
        else $error("control changed without write");
    COV_RD: cover property (axi_rsp_out.rvalid && axi_req_in.rready);
    COV_WR: cover property (axi_rsp_out.bvalid && axi_req_in.bready);
    COV_IRQ: cover property ($rose(irq_out));
endmodule // rmtl_asserts

bind rmtl_top rmtl_asserts rmtl_asserts_i (.clk_in(clk_in),
    .rstn_in(rstn_in), .axi_req_in(axi_req_in),
    .axi_rsp_out(axi_rsp_out), .modem_in(modem_in),
    .modem_ctl_out(modem_ctl_out), .irq_out(irq_out));

/* File: sim/testbench.sv */
// Self-checking bench for the modem timing and level register bank.
// Assumes the header, package and design files are compiled first.
`timescale 1ns/1ps

module testbench;
    import rmtl_pkg::*;
    logic            clk_in = 1'b0;
    logic            rstn_in = 1'b0;
    rmtl_axi_req_t   req = '0;
    rmtl_axi_rsp_t   rsp;
    rmtl_modem_in_t  mi = '0;
    rmtl_modem_ctl_t ctl;
    logic            irq;
    int              n_fail = 0;
    int              total_checks = 0;
    logic [31:0]     rd_v;
    logic [1:0]      rs_v;
    logic [23:0]     rows [13] = '{24'h22_ffff, 24'h23_5a5a, 24'h24_ff07,
        24'h25_a5a5, 24'h27_8080, 24'h2a_c3c3, 24'h2c_ff3f, 24'h2d_6969,
        24'h26_ff00, 24'h28_ff00, 24'h29_ff00, 24'h41_ff03, 24'h42_5151};
    logic [15:0]     rst_rows [9] = '{16'h23ae, 16'h2402, 16'h2600,
        16'h271e, 16'h2900, 16'h2a2a, 16'h2c2c, 16'h4100, 16'h2b00};
    always #5 clk_in = ~clk_in;
    rmtl_top rmtl_top_i (.clk_in(clk_in), .rstn_in(rstn_in),
        .axi_req_in(req), .axi_rsp_out(rsp), .modem_in(mi),
        .modem_ctl_out(ctl), .irq_out(irq));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] st = 4'hf);
        int n;
        @(posedge clk_in);
        req.awvalid <= 1'b1;
        req.awaddr <= {22'h0, idx, 2'b00};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= st;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_in);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid && req.bready) begin
                rs_v = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
            req.bready <= rsp.bvalid;
        end
        if (n == 100) begin
            n_fail++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [7:0] idx);
        int n;
        @(posedge clk_in);
        req.arvalid <= 1'b1;
        req.araddr <= {22'h0, idx, 2'b00};
        for (n = 0; n < 100; n++) begin
            @(posedge clk_in);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid && req.rready) begin
                rd_v = rsp.rdata;
                rs_v = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
            req.rready <= rsp.rvalid;
        end
        if (n == 100) begin
            n_fail++;
            stop_test();
        end
    endtask
    task automatic pulse(input logic [7:0] lv, input logic s);
        @(posedge clk_in);
        mi.level <= lv;
        mi.ant1 <= lv ^ 8'h91;
        mi.ant2 <= lv ^ 8'ha2;
        mi.fc_value <= {lv, 2'b11};
        mi.meas_valid <= ~s;
        mi.sync_found <= s;
        @(posedge clk_in);
        mi.meas_valid <= 1'b0;
        mi.sync_found <= 1'b0;
        wt(3);
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        wt(2);
        rstn_in <= 1'b1;
        wt(6);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chk(rd_v, {24'h0, rows[i][7:0]});
        end
        wt(2);
        chk({12'h0, ctl.nco_offset}, 32'h0005_ff5a);
        chk({21'h0, ctl.timing_gain}, 32'h0000_07a5);
        chk({31'h0, ctl.manch_flag}, 32'h0000_0001);
        chk({24'h0, ctl.fc_limit}, 32'h0000_00c3);
        chk({18'h0, ctl.ook_freeze, ctl.peak_det_en, ctl.ma_en,
            ctl.ook_count}, 32'h0000_3f69);
        wr(8'h2c, 8'h10);
        wt(2);
        chk({18'h0, ctl.ook_freeze, ctl.peak_det_en, ctl.ma_en,
            ctl.ook_count}, 32'h0000_1069);
        wr(8'h2c, 8'h28);
        wt(2);
        chk({18'h0, ctl.ook_freeze, ctl.peak_det_en, ctl.ma_en,
            ctl.ook_count}, 32'h0000_2869);
        wr(8'h30, 8'h55);
        chk({30'h0, rs_v}, 32'h0000_0000);
        rd(8'h30);
        chk(rd_v, 32'h0000_0000);
        chk({30'h0, rs_v}, 32'h0000_0000);
        wr(8'h2a, 8'h11, 4'h0);
        rd(8'h2a);
        chk(rd_v, 32'h0000_00c3);
        rd(8'h40);
        pulse(8'h80, 1'b0);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(8'h26);
        chk(rd_v, 32'h0000_0080);
        rd(8'h28);
        chk(rd_v, 32'h0000_0011);
        rd(8'h29);
        chk(rd_v, 32'h0000_0022);
        pulse(8'h81, 1'b0);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(8'h40);
        chk(rd_v, 32'h0000_0001);
        wt(3);
        chk({31'h0, irq}, 32'h0000_0000);
        pulse(8'had, 1'b1);
        chk({31'h0, irq}, 32'h0000_0001);
        pulse(8'h5a, 1'b0);
        rd(8'h2b);
        chk(rd_v, 32'h0000_00ad);
        rd(8'h2c);
        chk(rd_v, 32'h0000_00e8);
        wr(8'h41, 8'h01);
        wt(3);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(8'h40);
        chk(rd_v, 32'h0000_0002);
        @(posedge clk_in);
        rstn_in <= 1'b0;
        wt(2);
        rstn_in <= 1'b1;
        wt(6);
        foreach (rst_rows[i]) begin
            rd(rst_rows[i][15:8]);
            chk(rd_v, {24'h0, rst_rows[i][7:0]});
        end
        stop_test();
    end
endmodule // testbench
